// File: core/scka_top.sv
// key commands, alarm display codes and axis instances of the scale counter
`timescale 1ns/1ps
// Operation
// - missing unit shows error, value restarts zero
// - overspeed error held until reset
// - overflow shows F in top digit
// - power failure indication held until reset
// - corrupt settings flash error code 1-F
// - missing reference point raises reference error
// - power-on reset enters count, maybe waits reference
// - count reset clears incremental and peak
// - error reset clears all, may wait reference
// - start restarts peak, ignored at power-on/error
// - basis key toggles, ignored power-on/error
// - setup key enters basic or advanced settings
module scka_top
  import scka_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [NAXES-1:0] UNIT_PRESENT,
  input wire logic [NAXES-1:0] OVERSPEED,
  input wire logic [NAXES-1:0] REF_PULSE,
  input wire logic [NAXES-1:0] REF_TIMEOUT,
  input wire logic [NAXES*VALUE_W-1:0] DELTA,
  input wire logic POWER_FAIL,
  input wire logic STORE_CORRUPT,
  input wire logic [3:0] STORE_CODE,
  input wire logic MASTER_CAL,
  input wire logic RESET_KEY,
  input wire logic START_KEY,
  input wire logic DISPLAY_BASIS_TOGGLE_KEY,
  input wire logic SETUP_KEY,
  input wire logic SETTINGS_DONE,
  input wire logic [NAXES-1:0] AXIS_SELECT,
  output logic [1:0] MODE,
  output logic BASIC_SETTINGS,
  output logic ADVANCED_SETTINGS,
  output logic [NAXES*3-1:0] ALARM_CODE,
  output logic [NAXES-1:0] ABSOLUTE_VALUE_SHOWN,
  output logic [NAXES-1:0] OVERFLOW_DIGIT,
  output logic [NAXES*VALUE_W-1:0] SHOWN_VALUE,
  output logic [NAXES*VALUE_W-1:0] PEAK_VALUE,
  output logic STORE_ERROR_SHOWN,
  output logic [3:0] STORE_ERROR_CODE
);
  import scka_pkg::*;
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  // every pin but DELTA is asynchronous to CLOCK: two stages before use
  localparam int SW = 4 * NAXES + 12;
  wire logic [SW-1:0] pins = {UNIT_PRESENT, OVERSPEED, REF_PULSE, REF_TIMEOUT, POWER_FAIL,
    STORE_CORRUPT, STORE_CODE, MASTER_CAL, RESET_KEY, START_KEY, DISPLAY_BASIS_TOGGLE_KEY,
    SETUP_KEY, SETTINGS_DONE};
  // units start out present, so a release of reset raises no false missing-unit alarm
  localparam logic [SW-1:0] PIN_IDLE = {{NAXES{1'b1}}, {(SW-NAXES){1'b0}}};
  logic [SW-1:0] s1_q, s2_q, prev_q;
  logic [NAXES-1:0] sel_s1_q, sel_s2_q;
  always_ff @(posedge CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      prev_q <= PIN_IDLE;
      sel_s1_q <= '0;
      sel_s2_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      prev_q <= s2_q;
      sel_s1_q <= AXIS_SELECT;
      sel_s2_q <= sel_s1_q;
    end
  end
  wire logic [NAXES-1:0] unit_s = s2_q[SW-1 -: NAXES];
  wire logic [NAXES-1:0] speed_s = s2_q[SW-1-NAXES -: NAXES];
  wire logic [NAXES-1:0] refp_s = s2_q[SW-1-2*NAXES -: NAXES];
  wire logic [NAXES-1:0] refp_rise = refp_s & ~prev_q[SW-1-2*NAXES -: NAXES];
  wire logic [NAXES-1:0] reft_s = s2_q[SW-1-3*NAXES -: NAXES];
  wire logic pfail_s = s2_q[11];
  wire logic corrupt_s = s2_q[10];
  wire logic [3:0] code_s = s2_q[9:6];
  wire logic mcal_s = s2_q[5];
  wire logic [4:0] press = s2_q[4:0] & ~prev_q[4:0];
  wire logic reset_p = press[4];
  wire logic start_p = press[3];
  wire logic toggle_p = press[2];
  wire logic setup_p = press[1];
  wire logic setup_held = s2_q[1];
  wire logic done_p = press[0];
  wire logic [NAXES-1:0] sel = (sel_s2_q == '0) ? {NAXES{1'b1}} : sel_s2_q;
  scka_mode_t mode_q, mode_d;
  logic basic_q;
  logic [NAXES-1:0] wait_ax;
  wire logic in_count = (mode_q == SCKA_COUNT) || (mode_q == SCKA_WAIT_REF);
  wire logic any_wait = |wait_ax;
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      SCKA_POWERON: begin
        if (setup_held && reset_p)
          mode_d = SCKA_SETTINGS;
        else if (reset_p)
          mode_d = mcal_s ? SCKA_WAIT_REF : SCKA_COUNT;
      end
      SCKA_WAIT_REF: begin
        if (!any_wait && !reset_p)
          mode_d = SCKA_COUNT;
      end
      SCKA_COUNT: begin
        if (setup_p)
          mode_d = SCKA_SETTINGS;
        else if (any_wait)
          mode_d = SCKA_WAIT_REF;
      end
      SCKA_SETTINGS: begin
        if (done_p)
          mode_d = SCKA_COUNT;
      end
    endcase
  end
  always_ff @(posedge CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= SCKA_POWERON;
      basic_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (mode_d == SCKA_SETTINGS && mode_q != SCKA_SETTINGS)
        basic_q <= (mode_q == SCKA_POWERON);
    end
  end
  logic [31:0] blink_cnt_q;
  logic blink_q;
  always_ff @(posedge CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      blink_cnt_q <= '0;
      // flashing starts in the on phase so a corrupt store shows at once
      blink_q <= 1'b1;
    end else if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end
  // a power-on reset also restarts the axes, so they obey the same command path
  wire logic reset_cmd = reset_p && (mode_q != SCKA_SETTINGS);
  genvar g;
  generate
    for (g = 0; g < NAXES; g++) begin : gen_axis
      scka_axis_if ax_if ();
      scka_err_t err;
      logic abs_sel, waiting;
      logic [VALUE_W-1:0] inc, abs_v, peak;
      wire logic [VALUE_W-1:0] shown = abs_sel ? abs_v : inc;
      wire logic [VALUE_W-1:0] mag = shown[VALUE_W-1] ? (~shown + 1'b1) : shown;
      wire logic over = mag > DISPLAY_LIMIT;
      assign ax_if.reset_cmd = reset_cmd;
      assign ax_if.wait_ref = mcal_s && (mode_q == SCKA_POWERON || ax_if.in_error);
      assign ax_if.start_cmd = start_p && in_count && sel[g] && !ax_if.in_error;
      assign ax_if.toggle_cmd = toggle_p && in_count && sel[g] && !ax_if.in_error;
      assign wait_ax[g] = waiting;
      scka_axis u_axis (
        .clk(CLOCK),
        .rst_n(rst_n_q),
        .connected(unit_s[g]),
        .overspeed(speed_s[g]),
        .power_fail(pfail_s),
        .ref_pulse(refp_rise[g]),
        .ref_timeout(reft_s[g]),
        .delta(DELTA[g*VALUE_W +: VALUE_W]),
        .bus(ax_if.axis),
        .err_q(err),
        .abs_sel_q(abs_sel),
        .inc_q(inc),
        .abs_q(abs_v),
        .peak_q(peak),
        .waiting_q(waiting)
      );
      always_ff @(posedge CLOCK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          ALARM_CODE[g*3 +: 3] <= 3'h0;
          ABSOLUTE_VALUE_SHOWN[g] <= 1'b0;
          OVERFLOW_DIGIT[g] <= 1'b0;
          SHOWN_VALUE[g*VALUE_W +: VALUE_W] <= RESET_VALUE;
          PEAK_VALUE[g*VALUE_W +: VALUE_W] <= RESET_VALUE;
        end else begin
          ALARM_CODE[g*3 +: 3] <= err;
          ABSOLUTE_VALUE_SHOWN[g] <= abs_sel;
          OVERFLOW_DIGIT[g] <= over && (err == SCKA_ERR_NONE);
          SHOWN_VALUE[g*VALUE_W +: VALUE_W] <= shown;
          PEAK_VALUE[g*VALUE_W +: VALUE_W] <= peak;
        end
      end
    end
  endgenerate
  always_ff @(posedge CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      MODE <= 2'h0;
      BASIC_SETTINGS <= 1'b0;
      ADVANCED_SETTINGS <= 1'b0;
      STORE_ERROR_SHOWN <= 1'b0;
      STORE_ERROR_CODE <= ECODE_RESET;
    end else begin
      MODE <= mode_q;
      BASIC_SETTINGS <= (mode_q == SCKA_SETTINGS) && basic_q;
      ADVANCED_SETTINGS <= (mode_q == SCKA_SETTINGS) && !basic_q;
      // code 0 is not a valid error code, so it is shown as 1
      STORE_ERROR_SHOWN <= corrupt_s && blink_q;
      STORE_ERROR_CODE <= corrupt_s ? ((code_s == 4'h0) ? ECODE_MIN : code_s) : ECODE_RESET;
    end
  end
endmodule

// File: core/scka_pkg.sv
// shared constants and types for the scale counter alarm and key logic
package scka_pkg;
  localparam int NAXES = 3;
  localparam int VALUE_W = 24;
  localparam int DIGITS = 7;
  localparam logic [VALUE_W-1:0] RESET_VALUE = 24'h000000;
  localparam logic [VALUE_W-1:0] DISPLAY_LIMIT = 24'h0F423F;
  localparam logic [3:0] OVERFLOW_CHAR = 4'hF;
  localparam logic [3:0] ECODE_RESET = 4'h0;
  localparam logic [3:0] ECODE_MIN = 4'h1;
  localparam int BLINK_MS = 250;
  localparam int CLOCK_KHZ = 100000;
  localparam int BLINK_CYCLES = BLINK_MS * CLOCK_KHZ;
  typedef enum logic [1:0] {
    SCKA_POWERON,
    SCKA_WAIT_REF,
    SCKA_COUNT,
    SCKA_SETTINGS
  } scka_mode_t;
  typedef enum logic [2:0] {
    SCKA_ERR_NONE,
    SCKA_ERR_NOUNIT,
    SCKA_ERR_SPEED,
    SCKA_ERR_POWER,
    SCKA_ERR_REF
  } scka_err_t;
endpackage

// File: core/scka_axis_if.sv
// command and status bundle between the key logic and one axis
`timescale 1ns/1ps
interface scka_axis_if;
  logic reset_cmd;
  logic wait_ref;
  logic start_cmd;
  logic toggle_cmd;
  logic in_error;
  logic ref_seen;
  modport ctrl (output reset_cmd, output wait_ref, output start_cmd, output toggle_cmd,
    input in_error, input ref_seen);
  modport axis (input reset_cmd, input wait_ref, input start_cmd, input toggle_cmd,
    output in_error, output ref_seen);
endinterface

// File: core/scka_axis.sv
// one axis: error state, counts, peak, display basis
`timescale 1ns/1ps
module scka_axis
  import scka_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic connected,
  input wire logic overspeed,
  input wire logic power_fail,
  input wire logic ref_pulse,
  input wire logic ref_timeout,
  input wire logic signed [VALUE_W-1:0] delta,
  scka_axis_if.axis bus,
  output scka_err_t err_q,
  output logic abs_sel_q,
  output logic [VALUE_W-1:0] inc_q,
  output logic [VALUE_W-1:0] abs_q,
  output logic [VALUE_W-1:0] peak_q,
  output logic waiting_q
);
  import scka_pkg::*;
  scka_err_t err_d;
  wire logic in_err = (err_q != SCKA_ERR_NONE);
  wire logic counting = !in_err && !waiting_q;
  wire logic [VALUE_W-1:0] inc_n = inc_q + VALUE_W'(delta);
  wire logic [VALUE_W-1:0] mag = inc_n[VALUE_W-1] ? (~inc_n + 1'b1) : inc_n;
  wire logic err_reset = bus.reset_cmd && in_err;
  assign bus.in_error = in_err;
  assign bus.ref_seen = ref_pulse;
  // sticky faults; a fresh fault wins over a reset in the same cycle
  always_comb begin
    err_d = err_q;
    if (err_reset)
      err_d = SCKA_ERR_NONE;
    if (!connected)
      err_d = SCKA_ERR_NOUNIT;
    else if (overspeed)
      err_d = SCKA_ERR_SPEED;
    else if (power_fail)
      err_d = SCKA_ERR_POWER;
    else if (waiting_q && ref_timeout)
      err_d = SCKA_ERR_REF;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= SCKA_ERR_NONE;
      abs_sel_q <= 1'b0;
      inc_q <= RESET_VALUE;
      abs_q <= RESET_VALUE;
      peak_q <= RESET_VALUE;
      waiting_q <= 1'b0;
    end else begin
      err_q <= err_d;
      if (err_reset) begin
        inc_q <= RESET_VALUE;
        abs_q <= RESET_VALUE;
        peak_q <= RESET_VALUE;
        waiting_q <= bus.wait_ref;
      end else if (bus.reset_cmd && !waiting_q) begin
        inc_q <= RESET_VALUE;
        peak_q <= RESET_VALUE;
        waiting_q <= bus.wait_ref;
      end else if (bus.reset_cmd) begin
        waiting_q <= bus.wait_ref;
      end else if (waiting_q) begin
        if (ref_pulse)
          waiting_q <= 1'b0;
      end else if (counting) begin
        inc_q <= inc_n;
        abs_q <= abs_q + VALUE_W'(delta);
        if (bus.start_cmd)
          peak_q <= RESET_VALUE;
        else if (mag > peak_q)
          peak_q <= mag;
      end
      if (bus.toggle_cmd && counting)
        abs_sel_q <= !abs_sel_q;
    end
  end
endmodule

// File: bench/scka_top_assertions.sv
// port-level assertions for the scale counter alarm and key logic
`timescale 1ns/1ps
module scka_top_assertions
  import scka_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [NAXES-1:0] UNIT_PRESENT,
  input wire logic RESET_KEY,
  input wire logic [1:0] MODE,
  input wire logic BASIC_SETTINGS,
  input wire logic ADVANCED_SETTINGS,
  input wire logic [NAXES*3-1:0] ALARM_CODE,
  input wire logic [NAXES-1:0] ABSOLUTE_VALUE_SHOWN,
  input wire logic [NAXES*VALUE_W-1:0] PEAK_VALUE,
  input wire logic STORE_ERROR_SHOWN,
  input wire logic [3:0] STORE_ERROR_CODE
);
  logic [3:0] since_q;
  wire [2:0] code_a = ALARM_CODE[2:0];
  // saturates so a long quiet spell never looks like a fresh press
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) since_q <= 4'hF;
    else if (RESET_KEY) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_reset_in_count;
    $rose(RESET_KEY) && MODE == 2'h2 && code_a == 3'h0;
  endsequence
  sequence s_peak_cleared;
    ##[2:8] PEAK_VALUE[VALUE_W-1:0] == RESET_VALUE;
  endsequence
  AST_NO_UNIT: assert property (!UNIT_PRESENT[0] [*8] |-> code_a == 3'h1)
    else $error("missing unit not flagged");
  AST_FAULT_HELD: assert property ($past(code_a) inside {3'h2, 3'h3}
    && code_a != $past(code_a) |-> since_q < 4'h8) else $error("fault left without reset");
  AST_POWERON_IDLE: assert property (MODE == 2'h0 && $past(MODE) == 2'h0
    |-> $stable(PEAK_VALUE) && $stable(ABSOLUTE_VALUE_SHOWN)) else $error("key acted at power-on");
  AST_ERR_BASIS: assert property (code_a != 3'h0 && $past(code_a) != 3'h0
    |-> $stable(ABSOLUTE_VALUE_SHOWN[0])) else $error("basis changed on error axis");
  AST_STORE_CODE: assert property (STORE_ERROR_SHOWN |-> STORE_ERROR_CODE != ECODE_RESET)
    else $error("store error without code");
  AST_ADVANCED: assert property ($rose(ADVANCED_SETTINGS)
    |-> $past(MODE) == 2'h2 || $past(MODE, 2) == 2'h2) else $error("advanced not from count");
  AST_BASIC: assert property ($rose(BASIC_SETTINGS)
    |-> $past(MODE) == 2'h0 || $past(MODE, 2) == 2'h0) else $error("basic not from power-on");
  AST_RESET_PEAK: assert property (s_reset_in_count |-> s_peak_cleared)
    else $error("peak not cleared by reset");
endmodule
bind scka_top scka_top_assertions chk (.*);

// File: bench/scka_units.sv
// behavioural measuring units for the three axes
`timescale 1ns/1ps
module scka_units
  import scka_pkg::*;
(
  input wire logic clk,
  input wire logic [NAXES-1:0] plug,
  input wire logic [NAXES-1:0] fast,
  input wire logic [VALUE_W-1:0] step,
  output logic [NAXES-1:0] present = '0,
  output logic [NAXES-1:0] overspeed = '0,
  output logic [NAXES*VALUE_W-1:0] delta = '0
);
  logic flip_q = 1'h0;
  always @(posedge clk) begin
    flip_q <= !flip_q;
    present <= plug;
    overspeed <= fast & plug;
  end
  // an unplugged cable floats: show a moving pattern, never the last step
  for (genvar i = 0; i < NAXES; i++) begin : g_ax
    always @(posedge clk) delta[i*VALUE_W +: VALUE_W] <= plug[i] ? step : {VALUE_W{flip_q}};
  end
endmodule

// File: bench/scka_top_tb.sv
// self-checking bench for the scale counter alarm and key logic
`timescale 1ns/1ps
module scka_top_tb;
  import scka_pkg::*;
  logic CLOCK = 1'h0;
  logic RESETN = 1'h0;
  wire [NAXES-1:0] UNIT_PRESENT, OVERSPEED, ABSOLUTE_VALUE_SHOWN, OVERFLOW_DIGIT;
  wire [NAXES*VALUE_W-1:0] DELTA, SHOWN_VALUE, PEAK_VALUE;
  logic [NAXES-1:0] REF_PULSE = '0, REF_TIMEOUT = '0, AXIS_SELECT = '0, plug = '1, fast = '0;
  logic POWER_FAIL = 1'h0, STORE_CORRUPT = 1'h0, MASTER_CAL = 1'h0;
  logic [3:0] STORE_CODE = 4'h0;
  logic [VALUE_W-1:0] step = '0, keep;
  logic [4:0] keys = '0;
  wire RESET_KEY = keys[0], START_KEY = keys[1], DISPLAY_BASIS_TOGGLE_KEY = keys[2];
  wire SETUP_KEY = keys[3], SETTINGS_DONE = keys[4];
  wire [1:0] MODE;
  wire BASIC_SETTINGS, ADVANCED_SETTINGS, STORE_ERROR_SHOWN;
  wire [NAXES*3-1:0] ALARM_CODE;
  wire [3:0] STORE_ERROR_CODE;
  int n_mismatch = 0, comparisons = 0;
  localparam int RK = 0, SK = 1, TK = 2, UK = 3, DK = 4;
  scka_top dut (.*);
  scka_units units (.clk(CLOCK), .plug(plug), .fast(fast), .step(step),
    .present(UNIT_PRESENT), .overspeed(OVERSPEED), .delta(DELTA));
  always #5 CLOCK = ~CLOCK;
  task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // held three cycles so the two-flop key synchroniser cannot miss it
  task automatic press(input int k);
    keys[k] <= 1'h1;
    tick(3);
    keys[k] <= 1'h0;
    tick(8);
  endtask
  task automatic power_up();
    RESETN <= 1'h0;
    tick(3);
    RESETN <= 1'h1;
    tick(6);
  endtask
  task automatic t_poweron();
    power_up();
    chk("mode", MODE, 2'h0);
    press(SK);
    press(TK);
    chk("basis", ABSOLUTE_VALUE_SHOWN, '0);
    press(RK);
    chk("mode", MODE, 2'h2);
    $display("poweron done");
  endtask
  task automatic t_count();
    step <= 24'h000003;
    tick(10);
    step <= '0;
    tick(4);
    AXIS_SELECT <= 3'h1;
    press(TK);
    chk("basis", ABSOLUTE_VALUE_SHOWN, 3'h1);
    keep = SHOWN_VALUE[23:0];
    press(SK);
    press(RK);
    chk("abs", SHOWN_VALUE[23:0], keep);
    chk("inc", SHOWN_VALUE[47:24], '0);
    chk("peak", PEAK_VALUE, '0);
    step <= 24'h000005;
    tick(1);
    step <= 24'hFFFFFE;
    tick(1);
    step <= '0;
    press(SK);
    chk("peak", PEAK_VALUE, {24'h000005, 24'h000005, 24'h000003});
    press(TK);
    AXIS_SELECT <= '0;
    step <= 24'h0F4240;
    tick(1);
    step <= '0;
    tick(6);
    chk("overflow", OVERFLOW_DIGIT, 3'h7);
    press(RK);
    chk("overflow", OVERFLOW_DIGIT, '0);
    $display("count done");
  endtask
  task automatic t_speed();
    fast <= 3'h2;
    tick(4);
    fast <= '0;
    tick(8);
    chk("alarm", ALARM_CODE, 9'h010);
    press(TK);
    chk("basis", ABSOLUTE_VALUE_SHOWN, 3'h5);
    press(TK);
    press(RK);
    chk("alarm", ALARM_CODE, '0);
    chk("shown", SHOWN_VALUE, '0);
    press(TK);
    chk("abs", SHOWN_VALUE, {24'h0F4261, 24'h000000, 24'h0F4261});
    press(TK);
    $display("speed done");
  endtask
  task automatic t_power();
    POWER_FAIL <= 1'h1;
    tick(4);
    POWER_FAIL <= 1'h0;
    tick(30);
    chk("alarm", ALARM_CODE, 9'h0DB);
    press(RK);
    chk("alarm", ALARM_CODE, '0);
    for (int c = 0; c < 16; c++) begin
      STORE_CODE <= c[3:0];
      STORE_CORRUPT <= 1'h1;
      tick(6);
      chk("code", {STORE_ERROR_SHOWN, STORE_ERROR_CODE}, {1'b1, c ? c[3:0] : 4'h1});
    end
    STORE_CORRUPT <= 1'h0;
    tick(6);
    chk("store", {STORE_ERROR_SHOWN, STORE_ERROR_CODE}, '0);
    $display("power done");
  endtask
  task automatic t_setup();
    press(UK);
    chk("adv", {MODE, ADVANCED_SETTINGS}, 3'h7);
    press(DK);
    chk("mode", MODE, 2'h2);
    power_up();
    keys[UK] <= 1'h1;
    tick(3);
    press(RK);
    keys[UK] <= 1'h0;
    tick(6);
    chk("basic", BASIC_SETTINGS, 1'h1);
    press(DK);
    $display("setup done");
  endtask
  task automatic t_unplug();
    plug <= 3'h6;
    tick(12);
    chk("alarm", ALARM_CODE, 9'h001);
    plug <= '1;
    power_up();
    press(RK);
    chk("shown", {ALARM_CODE, SHOWN_VALUE[23:0]}, '0);
    $display("unplug done");
  endtask
  task automatic t_refcal();
    MASTER_CAL <= 1'h1;
    REF_PULSE <= '0;
    power_up();
    press(RK);
    chk("mode", MODE, 2'h1);
    REF_TIMEOUT <= 3'h4;
    tick(8);
    REF_TIMEOUT <= '0;
    REF_PULSE <= 3'h3;
    tick(8);
    chk("refalarm", {MODE, ALARM_CODE}, {2'h1, 9'h100});
    press(RK);
    chk("refalarm", {MODE, ALARM_CODE}, {2'h1, 9'h000});
    REF_PULSE <= 3'h7;
    tick(8);
    chk("mode", MODE, 2'h2);
    MASTER_CAL <= 1'h0;
    $display("refcal done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    t_poweron();
    t_count();
    t_speed();
    t_power();
    t_setup();
    t_unplug();
    t_refcal();
    tally_and_finish();
  end
endmodule
